/* core/mult_pkg.sv */
// Constants shared by the pipelined signed multiplier and its stage registers.
// Assumes a single rising-edge system clock and a classic Wishbone slave port.
package mult_pkg;
  // Operand and product widths
  localparam int OPERAND_W = 18;
  localparam int PRODUCT_W = 36;
  // Wishbone geometry
  localparam int WB_ADDR_W = 4;
  localparam int WB_DATA_W = 32;
  // Register byte offsets
  localparam logic [WB_ADDR_W-1:0] CTRL_OFF    = 4'h0;
  localparam logic [WB_ADDR_W-1:0] PROD_LO_OFF = 4'h4;
  localparam logic [WB_ADDR_W-1:0] PROD_HI_OFF = 4'h8;
  localparam logic [WB_ADDR_W-1:0] CHAIN_OFF   = 4'hC;
  // Control register fields
  localparam int CTRL_HOLD_CLEAR_BIT = 0;
  localparam int CTRL_W              = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 1'h0;
  // Bit position splitting the product into two words
  localparam int PROD_LO_W = 32;
  // Second operand source selection
  typedef enum logic { SRC_DIRECT, SRC_CASCADE } operand_src_t;
endpackage : mult_pkg

/* core/stage_reg.sv */
// One optional pipeline register with clock enable and synchronous clear.
// Assumes enable and clear already carry their final polarity.
`timescale 1ns/1ps
`default_nettype none
module stage_reg
  import mult_pkg::*;
#(
  parameter int         WIDTH   = 18,
  parameter logic       PRESENT = 1'h1
)(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  input  wire logic             enable,
  input  wire logic             clear,
  output logic      [WIDTH-1:0] q
);
  // Width check at elaboration
  if (WIDTH < 1)
  begin : g_bad_width
    $error("stage_reg width must be at least one");
  end

  logic [WIDTH-1:0] val_r;    // Stored value
  logic [WIDTH-1:0] val_nxt;  // Next stored value

  // Clear wins over enable, enable loads, else hold
  always_comb
  begin
    if (clear || reset)
      val_nxt = '0;
    else if (enable)
      val_nxt = d;
    else
      val_nxt = val_r;
  end

  // Register only
  always_ff @(posedge clock)
  begin
    val_r <= val_nxt;
  end

  // Inserted or removed by a static setting
  assign q = PRESENT ? val_r : d;

  // Checks only meaningful with the register inserted
  if (PRESENT)
  begin : g_checks
    a_clear_to_zero: assert property (@(posedge clock) disable iff (reset)
      clear |=> (q == '0)) else $error("stage clear did not zero the register");
    a_enable_loads: assert property (@(posedge clock) disable iff (reset)
      (enable && !clear) |=> (q == $past(d))) else $error("stage did not load operand");
    a_idle_holds: assert property (@(posedge clock) disable iff (reset)
      (!enable && !clear) |=> $stable(q)) else $error("stage changed while disabled");
    c_load_then_clear: cover property (@(posedge clock) disable iff (reset)
      (enable && !clear) ##1 clear);
  end
  else
  begin : g_bypass
    a_bypass_path: assert property (@(posedge clock) disable iff (reset)
      q == d) else $error("removed stage is not a plain path");
  end
endmodule : stage_reg
`default_nettype wire

/* core/signed_mult.sv */
// Signed 18 x 18 multiplier with optional operand and product registers.
// Assumes surrounding logic on the same clock drives operands and controls;
// software reaches a small register set over classic Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Chain output shows applied second operand
// - Registered chain output changes only on edges
// - First register loads when enabled, not cleared
// - First register clear zeroes it, beats enable
// - Second register loads selected source operand
// - Second register clear zeroes it, beats enable
// - Product register loads product when enabled
// - Product register clear zeroes it, beats enable
// - Clock and six controls may be inverted
// - Full 36-bit signed product of operands
// - Static select: direct or chain operand
// - Each register inserted or removed statically
// - Registered product updates only on edges
module signed_mult
  import mult_pkg::*;
#(
  parameter logic         FIRST_REG_ON    = 1'h1,
  parameter logic         SECOND_REG_ON   = 1'h1,
  parameter logic         PRODUCT_REG_ON  = 1'h1,
  parameter operand_src_t SECOND_SRC      = SRC_DIRECT,
  parameter logic         INV_CLOCK       = 1'h0,
  parameter logic         INV_FIRST_EN    = 1'h0,
  parameter logic         INV_FIRST_CLR   = 1'h0,
  parameter logic         INV_SECOND_EN   = 1'h0,
  parameter logic         INV_SECOND_CLR  = 1'h0,
  parameter logic         INV_PRODUCT_EN  = 1'h0,
  parameter logic         INV_PRODUCT_CLR = 1'h0
)(
  input  wire logic                            clock,
  input  wire logic                            reset,
  input  wire logic signed [mult_pkg::OPERAND_W-1:0] first_operand,
  input  wire logic signed [mult_pkg::OPERAND_W-1:0] second_operand,
  input  wire logic signed [mult_pkg::OPERAND_W-1:0] chain_operand_in,
  input  wire logic                            first_reg_enable,
  input  wire logic                            first_reg_clear,
  input  wire logic                            second_reg_enable,
  input  wire logic                            second_reg_clear,
  input  wire logic                            product_reg_enable,
  input  wire logic                            product_reg_clear,
  output logic signed [mult_pkg::OPERAND_W-1:0] chain_operand_out,
  output logic signed [mult_pkg::PRODUCT_W-1:0] product,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [mult_pkg::WB_ADDR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [mult_pkg::WB_DATA_W-1:0]  wb_dat_i,
  output logic      [mult_pkg::WB_DATA_W-1:0]  wb_dat_o,
  output logic                                 wb_ack_o
);
  import mult_pkg::*;

  // Effective clock after optional inversion
  logic reg_clock;  // Clock seen by every register
  assign reg_clock = clock ^ INV_CLOCK;

  // Controls after their static polarity setting
  logic first_en;     // First register enable, active high
  logic first_clr;    // First register clear, active high
  logic second_en;    // Second register enable, active high
  logic second_clr;   // Second register clear, active high
  logic product_en;   // Product register enable, active high
  logic product_clr;  // Product register clear, active high
  logic hold_clear;   // Software forced clear of all stages

  // Polarity applied before any register sees the signal
  assign first_en    = first_reg_enable ^ INV_FIRST_EN;
  assign first_clr   = (first_reg_clear ^ INV_FIRST_CLR) | hold_clear;
  assign second_en   = second_reg_enable ^ INV_SECOND_EN;
  assign second_clr  = (second_reg_clear ^ INV_SECOND_CLR) | hold_clear;
  assign product_en  = product_reg_enable ^ INV_PRODUCT_EN;
  assign product_clr = (product_reg_clear ^ INV_PRODUCT_CLR) | hold_clear;

  // Second operand source, fixed at build time
  logic signed [OPERAND_W-1:0] second_sel;  // Selected raw second operand
  assign second_sel = (SECOND_SRC == SRC_CASCADE) ? chain_operand_in : second_operand;

  // Operand stages
  logic signed [OPERAND_W-1:0] first_used;   // Operand applied to multiplier
  logic signed [OPERAND_W-1:0] second_used;  // Operand applied to multiplier

  stage_reg #(.WIDTH(OPERAND_W), .PRESENT(FIRST_REG_ON)) u_first_input_reg (
    .clock  (reg_clock),
    .reset  (reset),
    .d      (first_operand),
    .enable (first_en),
    .clear  (first_clr),
    .q      (first_used)
  );

  stage_reg #(.WIDTH(OPERAND_W), .PRESENT(SECOND_REG_ON)) u_second_input_reg (
    .clock  (reg_clock),
    .reset  (reset),
    .d      (second_sel),
    .enable (second_en),
    .clear  (second_clr),
    .q      (second_used)
  );

  // Chain output is whatever feeds the multiplier
  assign chain_operand_out = second_used;

  // Full precision signed product
  logic signed [PRODUCT_W-1:0] raw_product;  // Combinational product
  // Operands widened first so the product keeps all 36 bits
  assign raw_product = PRODUCT_W'(first_used) * PRODUCT_W'(second_used);

  stage_reg #(.WIDTH(PRODUCT_W), .PRESENT(PRODUCT_REG_ON)) u_product_reg (
    .clock  (reg_clock),
    .reset  (reset),
    .d      (raw_product),
    .enable (product_en),
    .clear  (product_clr),
    .q      (product)
  );

  // Wishbone slave state
  logic [CTRL_W-1:0]    ctrl_r;    // Control register
  logic [CTRL_W-1:0]    ctrl_nxt;
  logic                 ack_r;     // Bus acknowledge
  logic                 ack_nxt;
  logic [WB_DATA_W-1:0] rdata_r;   // Read data
  logic [WB_DATA_W-1:0] rdata_nxt;
  logic                 access;    // New request this cycle

  assign hold_clear = ctrl_r[CTRL_HOLD_CLEAR_BIT];
  assign access     = wb_cyc_i && wb_stb_i && !ack_r;

  // Decode, write and read mux
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    ack_nxt   = access;
    rdata_nxt = rdata_r;
    if (access)
    begin
      rdata_nxt = '0;
      unique case (wb_adr_i)
        CTRL_OFF:
        begin
          // Only lane 0 holds writable bits
          if (wb_we_i && wb_sel_i[0])
            ctrl_nxt = wb_dat_i[CTRL_W-1:0];
          rdata_nxt[CTRL_W-1:0] = ctrl_r;
        end
        PROD_LO_OFF:
          rdata_nxt = product[PROD_LO_W-1:0];
        PROD_HI_OFF:
          rdata_nxt[PRODUCT_W-PROD_LO_W-1:0] = product[PRODUCT_W-1:PROD_LO_W];
        CHAIN_OFF:
          rdata_nxt[OPERAND_W-1:0] = chain_operand_out;
        default:
          rdata_nxt = '0;  // Unmapped reads zero, writes ignored
      endcase
    end
  end

  // Register only
  always_ff @(posedge reg_clock)
  begin
    if (reset)
    begin
      ctrl_r  <= CTRL_RESET;
      ack_r   <= 1'h0;
      rdata_r <= '0;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Checks on the datapath and bus
  if (!SECOND_REG_ON)
  begin : g_chain_comb
    a_chain_follows: assert property (@(posedge reg_clock) disable iff (reset)
      chain_operand_out == second_sel) else $error("chain output not the selected operand");
  end
  else
  begin : g_chain_reg
    a_chain_on_edge: assert property (@(posedge reg_clock) disable iff (reset)
      (second_en && !second_clr) |=> chain_operand_out == $past(second_sel))
      else $error("registered chain output wrong");
  end

  if (!PRODUCT_REG_ON)
  begin : g_prod_comb
    a_product_exact: assert property (@(posedge reg_clock) disable iff (reset)
      product == first_used * second_used) else $error("product not full precision");
  end
  else
  begin : g_prod_reg
    a_product_update: assert property (@(posedge reg_clock) disable iff (reset)
      (!product_en && !product_clr) |=> $stable(product)) else $error("product moved idle");
  end

  a_source_select: assert property (@(posedge reg_clock) disable iff (reset)
    second_sel == ((SECOND_SRC == SRC_CASCADE) ? chain_operand_in : second_operand))
    else $error("wrong second operand source");
  a_ack_single: assert property (@(posedge reg_clock) disable iff (reset)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_ack_follows: assert property (@(posedge reg_clock) disable iff (reset)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");

  c_bus_write: cover property (@(posedge reg_clock) disable iff (reset)
    wb_ack_o && wb_we_i);
  c_hold_clear: cover property (@(posedge reg_clock) disable iff (reset)
    hold_clear ##1 !hold_clear);
  c_neg_product: cover property (@(posedge reg_clock) disable iff (reset)
    product[PRODUCT_W-1]);
endmodule : signed_mult
`default_nettype wire

/* test/operand_feeder.sv */
// Model of the user logic that feeds operands and stage controls.
// Assumes it shares the rising-edge clock of the multiplier it drives.
`timescale 1ns/1ps
`default_nettype none
module operand_feeder (
  input  wire logic                                  clock,
  output logic signed [mult_pkg::OPERAND_W-1:0]      first_operand,
  output logic signed [mult_pkg::OPERAND_W-1:0]      second_operand,
  output logic signed [mult_pkg::OPERAND_W-1:0]      chain_operand_in,
  output logic        [5:0]                          controls
);
  import mult_pkg::*;
  // Quiet values from time zero
  initial
  begin
    first_operand = 18'h00000;
    second_operand = 18'h00000;
    chain_operand_in = 18'h00000;
    controls = 6'h00;
  end
  // New operands and controls land just after an edge and then stand
  task automatic apply(input logic [17:0] a, input logic [17:0] b, input logic [17:0] c,
                       input logic [5:0] ctl);
    @(posedge clock);
    first_operand <= a;
    second_operand <= b;
    chain_operand_in <= c;
    controls <= ctl;
  endtask : apply
endmodule : operand_feeder
`default_nettype wire

/* test/pipelined_signed_multiplier_regs_tb.sv */
// Self-checking bench: fully registered multiplier plus a bypassed cascade copy and an inverted clock and control copy.
// Assumes the operand feeder model and the multiplier package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pipelined_signed_multiplier_regs_tb;
  import mult_pkg::*;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0;
  logic [3:0]         wb_adr_i = 4'h0;
  logic [3:0]         wb_sel_i = 4'h0;
  logic [31:0]        wb_dat_i = 32'h0;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic signed [17:0] a_op, b_op, c_op, chain_out, comb_chain, inv_chain;
  logic signed [35:0] product, comb_product, inv_product;
  logic [5:0]         ctl;
  logic [31:0]        rd, hi;
  int                 fails = 0;
  int                 comparisons = 0;
  // Free-running system clock, 40 ns period
  always #20 clock = ~clock;
  operand_feeder u_src (.clock(clock), .first_operand(a_op), .second_operand(b_op),
    .chain_operand_in(c_op), .controls(ctl));
  signed_mult dut (.clock(clock), .reset(reset), .first_operand(a_op), .second_operand(b_op),
    .chain_operand_in(c_op), .first_reg_enable(ctl[5]), .first_reg_clear(ctl[4]),
    .second_reg_enable(ctl[3]), .second_reg_clear(ctl[2]), .product_reg_enable(ctl[1]),
    .product_reg_clear(ctl[0]), .chain_operand_out(chain_out), .product(product),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  // Copy with every stage bypassed, fed from the cascade input
  signed_mult #(.FIRST_REG_ON(1'h0), .SECOND_REG_ON(1'h0), .PRODUCT_REG_ON(1'h0),
    .SECOND_SRC(SRC_CASCADE)) dut_comb (.clock(clock), .reset(reset), .first_operand(a_op),
    .second_operand(b_op), .chain_operand_in(c_op), .first_reg_enable(ctl[5]),
    .first_reg_clear(ctl[4]), .second_reg_enable(ctl[3]), .second_reg_clear(ctl[2]),
    .product_reg_enable(ctl[1]), .product_reg_clear(ctl[0]), .chain_operand_out(comb_chain),
    .product(comb_product), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o());
  // Copy with the clock and all six controls inverted, fed inverted controls
  signed_mult #(.INV_CLOCK(1'h1), .INV_FIRST_EN(1'h1), .INV_FIRST_CLR(1'h1),
    .INV_SECOND_EN(1'h1), .INV_SECOND_CLR(1'h1), .INV_PRODUCT_EN(1'h1),
    .INV_PRODUCT_CLR(1'h1)) dut_inv (.clock(clock), .reset(reset), .first_operand(a_op),
    .second_operand(b_op), .chain_operand_in(c_op), .first_reg_enable(~ctl[5]),
    .first_reg_clear(~ctl[4]), .second_reg_enable(~ctl[3]), .second_reg_clear(~ctl[2]),
    .product_reg_enable(~ctl[1]), .product_reg_clear(~ctl[0]), .chain_operand_out(inv_chain),
    .product(inv_product), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o());
  // Compare one value and count it
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                         output logic [31:0] q);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    // Only the watchdog ends a wait that never sees ack
    do
    begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer
  // Step past one edge, off the edge
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick
  // Apply operands with cascade value 5, then let n edges pass
  task automatic run(input logic [17:0] a, input logic [17:0] b, input logic [5:0] c, input int n);
    u_src.apply(a, b, 18'h00005, c);
    repeat (n) tick();
  endtask : run
  // Verdict and end of run
  task end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the fewer than a hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clock);
    fails++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    wb_xfer(1'b0, CHAIN_OFF, 32'h0, rd);
    check("chain reg", rd, 36'h0);
    check("product", product, 36'h0);
    wb_xfer(1'b1, 4'h2, 32'hFFFFFFFF, rd);
    wb_xfer(1'b0, 4'h2, 32'h0, rd);
    check("unmapped", rd, 36'h0);
    $display("test reset done");
    run(18'h20000, 18'h20000, 6'b101010, 1);
    check("chain out", chain_out, 18'sh20000);
    check("comb chain", comb_chain, 18'h00005);
    check("comb product", comb_product, 36'hFFFF60000);
    tick();
    check("product", product, 36'h400000000);
    check("inverted product", inv_product, 36'h400000000);
    wb_xfer(1'b0, PROD_LO_OFF, 32'h0, rd);
    wb_xfer(1'b0, PROD_HI_OFF, 32'h0, hi);
    check("product words", {hi[3:0], rd}, 36'h400000000);
    $display("test load done");
    run(18'h00003, 18'h00007, 6'b000000, 2);
    check("held chain", chain_out, 18'sh20000);
    check("inverted held chain", inv_chain, 18'sh20000);
    check("held product", product, 36'h400000000);
    run(18'h00003, 18'h00007, 6'b000010, 2);
    check("held operands", product, 36'h400000000);
    $display("test hold done");
    run(18'h3FFFD, 18'h00007, 6'b101010, 2);
    check("negative product", product, 36'hFFFFFFFEB);
    run(18'h3FFFD, 18'h00007, 6'b111010, 2);
    check("chain out", chain_out, 18'h00007);
    check("first cleared", product, 36'h0);
    check("inverted first clear", inv_product, 36'h0);
    run(18'h3FFFD, 18'h00007, 6'b101110, 1);
    check("second cleared", chain_out, 18'h00000);
    check("inverted second clear", inv_chain, 18'h00000);
    run(18'h3FFFD, 18'h00007, 6'b101010, 2);
    check("reloaded", product, 36'hFFFFFFFEB);
    run(18'h3FFFD, 18'h00007, 6'b101011, 1);
    check("product cleared", product, 36'h0);
    check("inverted product clear", inv_product, 36'h0);
    $display("test clear done");
    wb_xfer(1'b1, CTRL_OFF, 32'h1, rd);
    wb_xfer(1'b0, CTRL_OFF, 32'h0, rd);
    check("ctrl", rd, 36'h1);
    tick();
    check("hold clear chain", chain_out, 18'h00000);
    wb_xfer(1'b1, CTRL_OFF, 32'h0, rd);
    tick();
    tick();
    check("released chain", chain_out, 18'h00007);
    $display("test control done");
    end_sim();
  end
endmodule : pipelined_signed_multiplier_regs_tb
`default_nettype wire
